// file: verification/qbsp_ctrl_model.sv
// read side of the external memory controller: pops word pairs
// assumes the same clk as the port and a stall level from the bench
`timescale 1ns/1ps
module qbsp_ctrl_model
    import qbsp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              stall,
    input  wire logic              rd_valid,
    input  wire logic [DATA_W-1:0] first_read_word,
    input  wire logic [DATA_W-1:0] second_read_word,
    output logic                   rd_ready
);
    // ****************************************************************
    // pair capture
    // ****************************************************************
    logic [2*DATA_W-1:0] got [$];

    // a whole pair is taken at one edge, so no transfer is cut short
    always @(posedge clk) begin
        if (rst_b && rd_valid && rd_ready) begin
            got.push_back({second_read_word, first_read_word});
        end
        rd_ready <= rst_b & ~stall;
    end
endmodule // qbsp_ctrl_model

// file: verification/test_qdr_burst2_sram_port.sv
// self-checking bench of the burst-of-two sram port
// assumes one clk at 100 ns; the bench plays the controller's command side
`timescale 1ns/1ps
module test_qdr_burst2_sram_port
    import qbsp_pkg::*;
;
    logic                  clk, rst_b, read_sel_n, read_ready, write_sel_n;
    logic                  rd_valid, rd_ready, stall, out_clk_p, out_clk_n;
    logic                  outputs_on_main_clk, imp_too_weak, imp_too_strong;
    logic [ADDR_W-1:0]     read_addr, write_addr;
    logic [DATA_W-1:0]     w0, w1, q0, q1;
    logic [LANES-1:0]      m0, m1;
    logic [IMP_CODE_W-1:0] drive_code;
    logic [DATA_W-1:0]     mem [MEM_DEPTH];
    int                    errors, tests_run;
    bit                    ok;

    qbsp_port uut (.clk(clk), .rst_b(rst_b), .read_sel_n(read_sel_n),
        .read_addr(read_addr), .read_ready(read_ready),
        .write_sel_n(write_sel_n), .write_addr(write_addr),
        .first_write_word(w0), .byte_lane_mask_n_beat0(m0),
        .second_write_word(w1), .byte_lane_mask_n_beat1(m1),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .first_read_word(q0),
        .second_read_word(q1), .out_clk_p(out_clk_p),
        .out_clk_n(out_clk_n), .outputs_on_main_clk(outputs_on_main_clk),
        .imp_too_weak(imp_too_weak), .imp_too_strong(imp_too_strong),
        .drive_code(drive_code));
    qbsp_ctrl_model pm (.clk(clk), .rst_b(rst_b), .stall(stall),
        .rd_valid(rd_valid), .first_read_word(q0), .second_read_word(q1),
        .rd_ready(rd_ready));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task test_done;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input string nm, input logic [71:0] e, input logic [71:0] g);
        tests_run++;
        if (e !== g) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            errors++;
        end
    endtask

    task fail(input string nm);
        chk(nm, 72'h1, 72'h0);
        test_done();
    endtask

    // word0 and mask0 with the command, address and word1 one edge later
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0,
            input logic [LANES-1:0] k0, input logic [DATA_W-1:0] d1,
            input logic [LANES-1:0] k1);
        @(posedge clk);
        write_sel_n <= 1'b0;
        w0 <= d0;
        m0 <= k0;
        @(posedge clk);
        write_sel_n <= 1'b1;
        write_addr <= a;
        w1 <= d1;
        m1 <= k1;
        for (int g = 0; g < LANES; g++) begin
            if (!k0[g])
                mem[{a, 1'b0}][g*LANE_W +: LANE_W] = d0[g*LANE_W +: LANE_W];
            if (!k1[g])
                mem[{a, 1'b1}][g*LANE_W +: LANE_W] = d1[g*LANE_W +: LANE_W];
        end
    endtask

    // request held until an edge that sees read_ready high or the lim wait runs out
    task rd(input logic [ADDR_W-1:0] a, input int lim, output bit taken);
        int n;
        n = 0;
        @(posedge clk);
        read_sel_n <= 1'b0;
        read_addr <= a;
        @(negedge clk);
        while (read_ready !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        taken = (read_ready === 1'b1);
        @(posedge clk);
        read_sel_n <= 1'b1;
    endtask

    task getp(input string nm, input logic [DATA_W-1:0] e0,
              input logic [DATA_W-1:0] e1);
        int n;
        n = 0;
        while (pm.got.size() == 0) begin
            @(posedge clk);
            if (++n > 30) fail(nm);
        end
        chk(nm, {e1, e0}, pm.got.pop_front());
    endtask

    task chkrd(input logic [ADDR_W-1:0] a, input string nm);
        rd(a, 30, ok);
        if (!ok) fail(nm);
        getp(nm, mem[{a, 1'b0}], mem[{a, 1'b1}]);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_basic;
        int n;
        wr(8'h10, 36'h1_2345_6789, 4'h0, 36'h9_8765_4321, 4'h0);
        wr(8'hff, 36'h0_5555_aaaa, 4'h0, 36'hf_aaaa_5555, 4'h0);
        rd(8'h10, 30, ok);
        n = 0;
        while (rd_valid !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        // pend, stage, then the pair buffer: valid two edges after taking
        chk("read latency", 72'h2, 72'(n));
        getp("pair order", mem[{8'h10, 1'b0}], mem[{8'h10, 1'b1}]);
        chkrd(8'hff, "top pair");
    endtask

    task t_masks;
        for (int k = 0; k < 16; k++) begin
            wr(8'h20, '0, 4'h0, '0, 4'h0);
            wr(8'h20, {DATA_W{1'b1}}, LANES'(k), {DATA_W{1'b1}}, ~LANES'(k));
            chkrd(8'h20, "lane masks");
        end
    endtask

    task t_none;
        wr(8'h30, 36'h0_1111_2222, 4'h0, 36'h3_3333_4444, 4'h0);
        wr(8'h30, {DATA_W{1'b1}}, 4'hf, {DATA_W{1'b1}}, 4'hf);
        chkrd(8'h30, "all masked");
        @(posedge clk);
        w0 <= '0;
        m0 <= 4'h0;
        write_addr <= 8'h30;
        w1 <= '0;
        m1 <= 4'h0;
        repeat (3) @(posedge clk);
        chkrd(8'h30, "write deselect");
    endtask

    // read and write commands to the same address in one cycle; the write address follows one edge later
    task t_pass;
        wr(8'h50, 36'h0_dead_0000, 4'h0, 36'h0_beef_0000, 4'h0);
        @(posedge clk);
        read_sel_n <= 1'b0;
        read_addr <= 8'h50;
        write_sel_n <= 1'b0;
        w0 <= 36'h7_0000_1234;
        m0 <= 4'h0;
        @(posedge clk);
        read_sel_n <= 1'b1;
        write_sel_n <= 1'b1;
        write_addr <= 8'h50;
        w1 <= 36'h8_0000_5678;
        m1 <= 4'h0;
        getp("pass through", 36'h7_0000_1234, 36'h8_0000_5678);
    endtask

    task t_buffer;
        int taken;
        for (int i = 0; i < 8; i++)
            wr(8'h40 + 8'(i), 36'(i), 4'h0, 36'(i + 16), 4'h0);
        stall <= 1'b1;
        taken = 0;
        ok = 1'b1;
        while (ok && taken < 8) begin
            rd(8'h40 + 8'(taken), 6, ok);
            if (ok) taken++;
        end
        chk("stall refuses", 72'h0, 72'(ok));
        chk("buffer depth", 72'h1, 72'(taken >= BUF_DEPTH));
        stall <= 1'b0;
        for (int j = 0; j < taken; j++)
            getp("drain", 36'(j), 36'(j + 16));
        repeat (4) @(posedge clk);
        #1;
        chk("deselect idle", 72'h0, 72'(rd_valid));
    endtask

    // code moves once per counter period, one step each time
    task t_imp;
        int n;
        imp_too_weak <= 1'b1;
        for (int s = 1; s <= 2; s++) begin
            n = 0;
            while (drive_code === IMP_CODE_RST + 6'(s - 1) && n < 300) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk("drive step", 72'(IMP_CODE_RST + 6'(s)),
                72'(drive_code));
            if (s == 2)
                chk("eval period", 72'(IMP_PERIOD_CYC), 72'(n));
        end
        // the opposite comparator level walks the code back one step
        imp_too_weak <= 1'b0;
        imp_too_strong <= 1'b1;
        n = 0;
        while (drive_code === IMP_CODE_RST + 6'h2 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("drive step down", 72'(IMP_CODE_RST + 6'h1),
            72'(drive_code));
        imp_too_strong <= 1'b0;
    endtask

    task t_outclk(input logic v);
        int n;
        n = 0;
        out_clk_p <= v;
        out_clk_n <= v;
        while (outputs_on_main_clk !== v && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("output clock select", 72'(v),
            72'(outputs_on_main_clk));
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        {rst_b, stall, out_clk_p, out_clk_n, imp_too_weak, imp_too_strong} = '0;
        {read_sel_n, write_sel_n} = 2'h3;
        {read_addr, write_addr, w0, w1, m0, m1} = '0;
        errors = 0;
        tests_run = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk("reset state", {1'b1, 1'b0, 1'b0, IMP_CODE_RST},
            {read_ready, rd_valid, outputs_on_main_clk, drive_code});
        repeat (DLL_LOCK_CYC) @(posedge clk);
        t_basic();
        t_masks();
        t_none();
        t_pass();
        t_buffer();
        t_imp();
        t_outclk(1'b1);
        t_outclk(1'b0);
        test_done();
    end
endmodule // test_qdr_burst2_sram_port

// file: verilog/qbsp_imp_ctrl.sv
// periodic output driver impedance stepper
// assumes the comparator levels come from analog pins, hence synchronised
`timescale 1ns/1ps
module qbsp_imp_ctrl
    import qbsp_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  imp_too_weak,
    input  wire logic                  imp_too_strong,
    output logic [IMP_CODE_W-1:0]      drive_code
);

    typedef struct packed {
        logic [1:0]            weak_sync;
        logic [1:0]            strong_sync;
        logic [IMP_CNT_W-1:0]  cnt;
        logic [IMP_CODE_W-1:0] code;
    } qbsp_imp_state_type;

    qbsp_imp_state_type st_ff;
    qbsp_imp_state_type nxt_st;
    logic               eval;

    assign eval       = st_ff.cnt == IMP_CNT_W'(IMP_PERIOD_CYC - 1);
    assign drive_code = st_ff.code;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.weak_sync   = {st_ff.weak_sync[0], imp_too_weak};
        nxt_st.strong_sync = {st_ff.strong_sync[0], imp_too_strong};
        nxt_st.cnt         = st_ff.cnt + IMP_CNT_W'(1);
        if (eval) begin
            nxt_st.cnt = '0;
            // one binary-weighted step per evaluation limits output glitch
            if (st_ff.weak_sync[1] && !st_ff.strong_sync[1] &&
                st_ff.code != '1) begin
                nxt_st.code = st_ff.code + IMP_CODE_W'(1);
            end else if (st_ff.strong_sync[1] && !st_ff.weak_sync[1] &&
                         st_ff.code != '0) begin
                nxt_st.code = st_ff.code - IMP_CODE_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff      <= '0;
            st_ff.code <= IMP_CODE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    a_imp_restart : assert property (
        @(posedge clk) disable iff (!rst_b)
        eval |=> st_ff.cnt == '0)
        else $error("impedance counter did not restart after evaluation");

    a_imp_one_step : assert property (
        @(posedge clk) disable iff (!rst_b)
        st_ff.code != $past(st_ff.code) |->
            (st_ff.code == $past(st_ff.code) + IMP_CODE_W'(1) ||
             st_ff.code == $past(st_ff.code) - IMP_CODE_W'(1)))
        else $error("impedance code moved by more than one step");

    c_imp_step : cover property (@(posedge clk) disable iff (!rst_b)
        eval ##1 $changed(st_ff.code));

endmodule // qbsp_imp_ctrl

// file: verilog/qbsp_pair_buf.sv
// two-entry buffer of read word pairs between the read path and the port
// assumes in_valid is only raised by logic on the same clock
`timescale 1ns/1ps
module qbsp_pair_buf
    import qbsp_pkg::*;
#(
    parameter int W     = 2 * DATA_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    typedef struct packed {
        logic [1:0] rd_ptr;
        logic [1:0] wr_ptr;
        logic [1:0] level;
        logic       out_v;
    } qbsp_buf_state_type;

    qbsp_buf_state_type st_ff;
    qbsp_buf_state_type nxt_st;
    logic [W-1:0]       mem_ff [DEPTH];
    logic               push;
    logic               pop;

    assign push      = in_valid && (st_ff.level != 2'(DEPTH));
    assign pop       = (st_ff.level != 2'h0) && out_ready;
    assign in_ready  = st_ff.level != 2'(DEPTH);
    assign out_valid = st_ff.out_v;
    assign out_data  = mem_ff[st_ff.rd_ptr[0]];

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr_ptr = st_ff.wr_ptr + 2'h1;
        end
        if (pop) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + 2'h1;
        end
        nxt_st.level = st_ff.level + {1'b0, push} - {1'b0, pop};
        // valid kept in its own flop so the port output is registered
        nxt_st.out_v = nxt_st.level != 2'h0;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // storage needs no reset; level guards every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[st_ff.wr_ptr[0]] <= in_data;
        end
    end

    a_buf_no_overfill : assert property (@(posedge clk) disable iff (!rst_b)
        st_ff.level <= 2'(DEPTH))
        else $error("pair buffer holds more than its depth");

endmodule // qbsp_pair_buf

// file: verilog/qbsp_pkg.sv
// constants, types and lane layout for the burst-of-two sram port
// assumes one clock (the main input clock) and a same-clock controller
package qbsp_pkg;

    // ****************************************************************
    // widths and lane layout
    // ****************************************************************
    localparam int DATA_W     = 36;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;
    localparam int X18_DATA_W = 18;
    localparam int X18_LANES  = 2;
    localparam int X8_DATA_W  = 8;
    localparam int X8_LANES   = 2;
    localparam int X8_LANE_W  = 4;
    localparam int ADDR_W     = 8;
    localparam int MEM_DEPTH  = 2 ** (ADDR_W + 1);
    localparam int BUF_DEPTH  = 2;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS  = 100;
    localparam int DLL_LOCK_CYC   = 1024;
    localparam int IMP_PERIOD_NS  = 12800;
    localparam int IMP_PERIOD_CYC = IMP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int IMP_CNT_W      = 8;
    localparam int IMP_CODE_W     = 6;
    localparam logic [IMP_CODE_W-1:0] IMP_CODE_RST = 6'h20;

    // ****************************************************************
    // state encodings
    // ****************************************************************
    typedef enum logic [0:0] {
        WR_IDLE = 1'b0,
        WR_ADDR = 1'b1
    } qbsp_wr_state_type;

    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_PEND = 1'b1
    } qbsp_rd_state_type;

endpackage : qbsp_pkg

// file: verilog/qbsp_port.sv
// command and data port of a burst-of-two separate-i/o sram, x36 lanes
// assumes the controller runs on clk; the half-cycle edge of the main
// clock pair is modelled as the following clk edge
`timescale 1ns/1ps
module qbsp_port
    import qbsp_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  read_sel_n,
    input  wire logic [ADDR_W-1:0]     read_addr,
    output logic                       read_ready,
    input  wire logic                  write_sel_n,
    input  wire logic [ADDR_W-1:0]     write_addr,
    input  wire logic [DATA_W-1:0]     first_write_word,
    input  wire logic [LANES-1:0]      byte_lane_mask_n_beat0,
    input  wire logic [DATA_W-1:0]     second_write_word,
    input  wire logic [LANES-1:0]      byte_lane_mask_n_beat1,
    output logic                       rd_valid,
    input  wire logic                  rd_ready,
    output logic [DATA_W-1:0]          first_read_word,
    output logic [DATA_W-1:0]          second_read_word,
    input  wire logic                  out_clk_p,
    input  wire logic                  out_clk_n,
    output logic                       outputs_on_main_clk,
    input  wire logic                  imp_too_weak,
    input  wire logic                  imp_too_strong,
    output logic [IMP_CODE_W-1:0]      drive_code
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        qbsp_wr_state_type   wr_state;
        logic [DATA_W-1:0]   wr_word0;
        logic [LANES-1:0]    wr_mask0;
        qbsp_rd_state_type   rd_state;
        logic [ADDR_W-1:0]   rd_addr;
        logic                data_v;
        logic [DATA_W-1:0]   data0;
        logic [DATA_W-1:0]   data1;
        logic                read_ready;
        logic [1:0]          clkp_sync;
        logic [1:0]          clkn_sync;
        logic                main_clk_out;
    } qbsp_port_state_type;

    qbsp_port_state_type st_ff;
    qbsp_port_state_type nxt_st;

    logic [DATA_W-1:0]   mem_ff [MEM_DEPTH];
    logic [DATA_W-1:0]   keep0;
    logic [DATA_W-1:0]   keep1;
    logic                commit;
    logic                we0;
    logic                we1;
    logic                rd_load;
    logic                match;
    logic                stage_free;
    logic                buf_in_ready;
    logic [2*DATA_W-1:0] buf_out;
    logic [ADDR_W:0]     word_a0;
    logic [ADDR_W:0]     word_a1;
    logic [ADDR_W:0]     read_a0;
    logic [ADDR_W:0]     read_a1;

    // ****************************************************************
    // lane masks
    // ****************************************************************
    // a low mask bit keeps the lane; lanes are independent and any
    // combination is legal, so the map is a plain per-lane replication
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign keep0[g*LANE_W +: LANE_W] =
                {LANE_W{~st_ff.wr_mask0[g]}};
            assign keep1[g*LANE_W +: LANE_W] =
                {LANE_W{~byte_lane_mask_n_beat1[g]}};
        end
    endgenerate

    // ****************************************************************
    // write machine
    // ****************************************************************
    // second beat, its mask and the address arrive one edge after the
    // command, so the commit happens then and covers both beats
    assign commit  = st_ff.wr_state == WR_ADDR;
    assign we0     = commit && (keep0 != '0);
    assign we1     = commit && (keep1 != '0);
    assign word_a0 = {write_addr, 1'b0};
    assign word_a1 = {write_addr, 1'b1};

    // ****************************************************************
    // read machine
    // ****************************************************************
    assign rd_load    = !read_sel_n && st_ff.read_ready;
    assign stage_free = !st_ff.data_v || buf_in_ready;
    assign read_a0    = {st_ff.rd_addr, 1'b0};
    assign read_a1    = {st_ff.rd_addr, 1'b1};
    assign match      = commit && (write_addr == st_ff.rd_addr);

    always_comb begin
        nxt_st = st_ff;

        // write port: both machines update on the same edge
        if (!write_sel_n) begin
            nxt_st.wr_state = WR_ADDR;
            nxt_st.wr_word0 = first_write_word;
            nxt_st.wr_mask0 = byte_lane_mask_n_beat0;
        end else begin
            nxt_st.wr_state = WR_IDLE;
        end

        // data stage drains into the buffer
        if (st_ff.data_v && buf_in_ready) begin
            nxt_st.data_v = 1'b0;
        end

        // a pending read is composed when the stage can take it; an
        // address match with the commit passes the new data through
        if (st_ff.rd_state == RD_PEND && stage_free) begin
            nxt_st.data_v   = 1'b1;
            nxt_st.data0    = mem_ff[read_a0];
            nxt_st.data1    = mem_ff[read_a1];
            if (match) begin
                nxt_st.data0 = (st_ff.wr_word0 & keep0) |
                               (mem_ff[read_a0] & ~keep0);
                nxt_st.data1 = (second_write_word & keep1) |
                               (mem_ff[read_a1] & ~keep1);
            end
            nxt_st.rd_state = RD_IDLE;
        end

        if (rd_load) begin
            nxt_st.rd_state = RD_PEND;
            nxt_st.rd_addr  = read_addr;
        end

        // ready only while no read is jammed behind a full stage, so an
        // accepted read is never overwritten; a stalled read loses the
        // pass-through window, which the controller avoids by draining
        nxt_st.read_ready = !(nxt_st.rd_state == RD_PEND &&
                              nxt_st.data_v);

        // output clock pins are asynchronous levels: two flops first
        nxt_st.clkp_sync    = {st_ff.clkp_sync[0], out_clk_p};
        nxt_st.clkn_sync    = {st_ff.clkn_sync[0], out_clk_n};
        nxt_st.main_clk_out = st_ff.clkp_sync[1] &&
                              st_ff.clkn_sync[1];
    end

    // all sequencing is on clk; the output clocks only steer the
    // launch selection and never clock any state here
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff            <= '0;
            st_ff.wr_state   <= WR_IDLE;
            st_ff.rd_state   <= RD_IDLE;
            st_ff.read_ready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // array
    // ****************************************************************
    // masked lanes keep their old contents; an all-masked beat writes
    // nothing at all
    always_ff @(posedge clk) begin
        if (we0) begin
            mem_ff[word_a0] <= (st_ff.wr_word0 & keep0) |
                               (mem_ff[word_a0] & ~keep0);
        end
        if (we1) begin
            mem_ff[word_a1] <= (second_write_word & keep1) |
                               (mem_ff[word_a1] & ~keep1);
        end
    end

    // ****************************************************************
    // output buffer and impedance
    // ****************************************************************
    qbsp_pair_buf #(
        .W     (2 * DATA_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (st_ff.data_v),
        .in_ready  (buf_in_ready),
        .in_data   ({st_ff.data1, st_ff.data0}),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (buf_out)
    );

    qbsp_imp_ctrl u_imp (
        .clk            (clk),
        .rst_b          (rst_b),
        .imp_too_weak   (imp_too_weak),
        .imp_too_strong (imp_too_strong),
        .drive_code     (drive_code)
    );

    assign first_read_word     = buf_out[DATA_W-1:0];
    assign second_read_word    = buf_out[2*DATA_W-1:DATA_W];
    assign read_ready          = st_ff.read_ready;
    assign outputs_on_main_clk = st_ff.main_clk_out;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_read_deselect : assert property (
        @(posedge clk) disable iff (!rst_b)
        (read_sel_n && st_ff.rd_state == RD_IDLE)
            |=> st_ff.rd_state == RD_IDLE)
        else $error("deselected read started a read");

    a_read_word_time : assert property (
        @(posedge clk) disable iff (!rst_b)
        (rd_load && !st_ff.data_v && st_ff.rd_state == RD_IDLE)
            |=> st_ff.rd_state == RD_PEND ##1 st_ff.data_v)
        else $error("read data not staged one edge after the read");

    a_write_addr_phase : assert property (
        @(posedge clk) disable iff (!rst_b)
        !write_sel_n |=> commit)
        else $error("write command not followed by address phase");

    a_write_masked_all : assert property (
        @(posedge clk) disable iff (!rst_b)
        (commit && (&st_ff.wr_mask0) && (&byte_lane_mask_n_beat1))
            |-> !we0 && !we1)
        else $error("fully masked write stored data");

    a_write_deselect : assert property (
        @(posedge clk) disable iff (!rst_b)
        write_sel_n |=> !commit)
        else $error("deselected write committed");

    a_pass_through : assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_ff.rd_state == RD_PEND && stage_free && match &&
         st_ff.wr_mask0 == '0 && byte_lane_mask_n_beat1 == '0)
            |=> st_ff.data0 == $past(st_ff.wr_word0) &&
                st_ff.data1 == $past(second_write_word))
        else $error("same-address read did not pass new write data");

    a_ready_no_loss : assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_ff.rd_state == RD_PEND && !stage_free) |-> !st_ff.read_ready)
        else $error("read port ready while a read is jammed");

    a_main_clk_out : assert property (
        @(posedge clk) disable iff (!rst_b)
        (out_clk_p && out_clk_n) [*4] |-> st_ff.main_clk_out)
        else $error("tied output clocks did not select main clock");

    c_read_write_same : cover property (@(posedge clk) disable iff (!rst_b)
        rd_load && !write_sel_n);

    c_pass_through : cover property (@(posedge clk) disable iff (!rst_b)
        st_ff.rd_state == RD_PEND && stage_free && match);

    c_buffer_stall : cover property (@(posedge clk) disable iff (!rst_b)
        rd_valid && !rd_ready && !st_ff.read_ready);

endmodule // qbsp_port
